// ==== core/deepc_pkg.sv ====
// Package: constants and types for the data EEPROM program/erase controller
// How it works
// - Array occupies program addresses 7FFE00h through 7FFFFFh.
// - Array holds 256 words.
// - Words are 16 bits, each individually readable and writable.
// - Processor keeps running during erase or write; a cycle never stalls the bus.
// - Unlock only by writing 55h then AAh to the key register.
// - After unlock, one following cycle accepts a control write.
// - Key register is write-only, used only for protection.
// - Bit 15 starts a cycle; software sets only; hardware clears.
// - Bit 14 permits operations; device clears it on completion.
// - Bit 13 set when external or watchdog reset aborts a cycle.
// - Bit 12 clear means erase target before writing.
// - Bit 6 selects erase when set, write when clear.
// - Erase codes 011010, 011001, 011000 erase eight, four, one words.
// - Erase code 0100xx erases the whole array.
// - Write code 0001xx programs one word from the latch.
// - Control bits 11 to 7 always read zero.
// - Target address comes from the last table write that falls inside the array.
// - Target address least significant bit is always zero.
// - Unassigned operation codes change no word; the cycle ends at once, clearing permit and raising the flag.
// - Completion raises the completion interrupt flag.
package deepc_pkg;

	// ==========================================================
	// Register map (word offsets times four)
	localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
	localparam logic [3:0]  ADDR_KEY        = 4'h4;
	localparam logic [3:0]  ADDR_STATUS     = 4'h8;
	localparam logic [3:0]  ADDR_ARRAY_DATA = 4'hc;

	// ==========================================================
	// Control fields
	localparam int          BIT_START    = 15;
	localparam int          BIT_PERMIT   = 14;
	localparam int          BIT_ABORT    = 13;
	localparam int          BIT_SKIP     = 12;
	localparam int          BIT_ERASE    = 6;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK = 16'h707f;

	// ==========================================================
	// Keys and operation codes
	localparam logic [7:0]  KEY_FIRST  = 8'h55;
	localparam logic [7:0]  KEY_SECOND = 8'haa;
	localparam logic [5:0]  OP_ERASE8  = 6'h1a;
	localparam logic [5:0]  OP_ERASE4  = 6'h19;
	localparam logic [5:0]  OP_ERASE1  = 6'h18;
	localparam logic [3:0]  OP_BULK    = 4'h4;
	localparam logic [3:0]  OP_WRITE   = 4'h1;

	// ==========================================================
	// Array geometry
	localparam int          WORDS      = 256;
	localparam logic [23:0] ARRAY_BASE = 24'h7ffe00;
	localparam logic [23:0] ARRAY_TOP  = 24'h7fffff;

	// ==========================================================
	// Timing: cell program time, as a parameterised count
	localparam int          CLK_MHZ       = 50;
	localparam int          CELL_TIME_US  = 4;
	localparam int          CELL_CYCLES   = CELL_TIME_US * CLK_MHZ;

	typedef enum logic [3:0]
	{
		DEEPC_IDLE  = 4'b0001,
		DEEPC_ERASE = 4'b0010,
		DEEPC_WRITE = 4'b0100,
		DEEPC_DONE  = 4'b1000
	} deepc_state_t;

	typedef struct packed
	{
		logic        start;
		logic        permit;
		logic        abort;
		logic        skip;
		logic        erase;
		logic [5:0]  opcode;
	} deepc_ctrl_t;

	typedef struct packed
	{
		logic [23:0] addr;
		logic [15:0] data;
		logic        valid;
	} deepc_tblwt_t;

	function automatic logic [15:0] deepc_ctrl_word(input deepc_ctrl_t c);
		deepc_ctrl_word = {c.start, c.permit, c.abort, c.skip, 5'h00, c.erase, c.opcode};
	endfunction

	function automatic logic in_array(input logic [23:0] a);
		in_array = (a >= ARRAY_BASE) && (a <= ARRAY_TOP);
	endfunction

endpackage

// ==== core/deepc_cell_timer.sv ====
// Cell program/erase timer for the data EEPROM controller
`timescale 1ns/1ns
`default_nettype none
module deepc_cell_timer
	import deepc_pkg::*;
#(
	parameter int CYCLES = CELL_CYCLES
)
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic kick,
	output logic      expired
);
	logic [15:0] count_reg;
	logic [15:0] count_next;

	always_comb
	begin
		count_next = count_reg;
		if (kick)
			count_next = 16'(CYCLES);
		else if (count_reg != 16'h0000)
			count_next = count_reg - 16'h0001;
	end

	assign expired = (count_reg == 16'h0001);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_reg <= 16'h0000;
		else
			count_reg <= count_next;
	end
endmodule
`default_nettype wire

// ==== core/deepc_top.sv ====
// Data EEPROM program/erase controller with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module deepc_top
	import deepc_pkg::*;
#(
	parameter int CELL_CYC = CELL_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        tblwt_valid,
	input  wire logic [23:0] tblwt_addr,
	input  wire logic [15:0] tblwt_data,
	input  wire logic [23:0] tblrd_addr,
	output logic [15:0]      tblrd_data,
	input  wire logic        external_reset_pin,
	input  wire logic        watchdog_reset,
	output logic             completion_interrupt_flag,
	output logic             busy
);
	// ==========================================================
	// State
	typedef struct packed
	{
		deepc_ctrl_t  ctrl;
		deepc_state_t state;
		logic         key_first;
		logic         window;
		logic         done_pulse;
		logic         rd_ack;
		logic [31:0]  rdata;
		logic [23:0]  target;
		logic [15:0]  latch;
		logic [7:0]   index;
		logic [8:0]   remaining;
		logic         then_write;
		logic [15:0]  rd_word;
	} deepc_st_t;

	deepc_st_t   s_reg;
	deepc_st_t   s_next;
	logic [15:0] array_reg [WORDS];
	logic        cell_kick;
	logic        cell_expired;
	logic        wr_access;
	logic        rd_access;
	logic        lanes_low;
	logic [15:0] ctrl_word;
	logic [15:0] wdat;
	logic        mem_we;
	logic [15:0] mem_wdata;
	logic        sys_reset;

	deepc_cell_timer #(
		.CYCLES (CELL_CYC)
	) u_timer (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.kick     (cell_kick),
		.expired  (cell_expired)
	);

	// No stall: writes answer at once, reads one cycle later
	assign avs_waitrequest = avs_read && !s_reg.rd_ack;
	assign wr_access = avs_write;
	assign rd_access = avs_read && !s_reg.rd_ack;
	assign lanes_low = avs_byteenable[0] && avs_byteenable[1];
	assign wdat = avs_writedata[15:0];
	assign ctrl_word = deepc_ctrl_word(s_reg.ctrl);
	assign avs_readdata = s_reg.rdata;
	assign tblrd_data = s_reg.rd_word;
	assign completion_interrupt_flag = s_reg.done_pulse;
	assign busy = s_reg.ctrl.start;
	assign sys_reset = external_reset_pin || watchdog_reset;

	// ==========================================================
	// Next state
	always_comb
	begin
		logic start_ok;
		logic [5:0] op;
		start_ok = 1'b0;
		op = s_reg.ctrl.opcode;
		s_next = s_reg;
		s_next.done_pulse = 1'b0;
		s_next.rd_ack = rd_access;
		cell_kick = 1'b0;
		mem_we = 1'b0;
		mem_wdata = 16'hffff;

		// Window lasts exactly the cycle after the second key
		s_next.window = 1'b0;

		// Table write captures address and data, LSb forced even
		if (tblwt_valid && in_array(tblwt_addr))
		begin
			s_next.target = {tblwt_addr[23:1], 1'b0};
			s_next.latch = tblwt_data;
		end

		// Array reads on word index
		s_next.rd_word = array_reg[tblrd_addr[8:1]];

		if (wr_access && lanes_low)
		begin
			unique case (avs_address)
				ADDR_KEY:
				begin
					if (wdat[7:0] == KEY_FIRST)
						s_next.key_first = 1'b1;
					else if (s_reg.key_first && wdat[7:0] == KEY_SECOND)
					begin
						s_next.key_first = 1'b0;
						s_next.window = 1'b1;
					end
					else
						s_next.key_first = 1'b0;
				end
				ADDR_CONTROL:
				begin
					if (!s_reg.ctrl.start)
					begin
						s_next.ctrl.permit = wdat[BIT_PERMIT];
						s_next.ctrl.abort = wdat[BIT_ABORT];
						s_next.ctrl.skip = wdat[BIT_SKIP];
						s_next.ctrl.erase = wdat[BIT_ERASE];
						s_next.ctrl.opcode = wdat[5:0];
						// Start needs the window and an already-set permit
						start_ok = wdat[BIT_START] && wdat[BIT_PERMIT]
							&& s_reg.window && s_reg.ctrl.permit;
					end
					s_next.key_first = 1'b0;
				end
				default:
					s_next.key_first = 1'b0;
			endcase
		end

		if (rd_access)
		begin
			unique case (avs_address)
				ADDR_CONTROL:    s_next.rdata = {16'h0000, ctrl_word};
				ADDR_STATUS:     s_next.rdata = {28'h0000000, s_reg.state};
				ADDR_ARRAY_DATA: s_next.rdata = {16'h0000, s_reg.latch};
				default:         s_next.rdata = 32'h00000000;
			endcase
		end

		// Launch
		if (start_ok)
		begin
			op = wdat[5:0];
			s_next.ctrl.start = 1'b1;
			s_next.ctrl.abort = 1'b0;
			s_next.then_write = 1'b0;
			if (wdat[BIT_ERASE])
			begin
				if (op[5:2] == OP_BULK)
				begin
					s_next.index = 8'h00;
					s_next.remaining = 9'(WORDS);
				end
				else if (op == OP_ERASE8)
				begin
					s_next.index = s_reg.target[8:1];
					s_next.remaining = 9'd8;
				end
				else if (op == OP_ERASE4)
				begin
					s_next.index = s_reg.target[8:1];
					s_next.remaining = 9'd4;
				end
				else if (op == OP_ERASE1)
				begin
					s_next.index = s_reg.target[8:1];
					s_next.remaining = 9'd1;
				end
				else
					s_next.remaining = 9'd0;
				s_next.state = (s_next.remaining != 9'd0) ? DEEPC_ERASE : DEEPC_DONE;
			end
			else if (op[5:2] == OP_WRITE)
			begin
				s_next.index = s_reg.target[8:1];
				s_next.remaining = 9'd1;
				s_next.then_write = 1'b1;
				s_next.state = wdat[BIT_SKIP] ? DEEPC_WRITE : DEEPC_ERASE;
			end
			else
				s_next.state = DEEPC_DONE;
			cell_kick = (s_next.state != DEEPC_DONE);
		end

		// Self-timed sequencer; runs in background
		unique case (s_reg.state)
			DEEPC_IDLE: ;
			DEEPC_ERASE:
			begin
				if (cell_expired)
				begin
					mem_we = 1'b1;
					mem_wdata = 16'hffff;
					if (s_reg.then_write)
					begin
						s_next.state = DEEPC_WRITE;
						cell_kick = 1'b1;
					end
					else if (s_reg.remaining == 9'd1)
						s_next.state = DEEPC_DONE;
					else
					begin
						s_next.index = s_reg.index + 8'h01;
						s_next.remaining = s_reg.remaining - 9'd1;
						cell_kick = 1'b1;
					end
				end
			end
			DEEPC_WRITE:
			begin
				if (cell_expired)
				begin
					mem_we = 1'b1;
					mem_wdata = s_reg.latch;
					s_next.state = DEEPC_DONE;
				end
			end
			DEEPC_DONE:
			begin
				s_next.ctrl.start = 1'b0;
				s_next.ctrl.permit = 1'b0;
				s_next.done_pulse = 1'b1;
				s_next.state = DEEPC_IDLE;
			end
			default:
				s_next.state = DEEPC_IDLE;
		endcase

		// External or watchdog reset cuts a cycle short
		if (sys_reset)
		begin
			if (s_reg.ctrl.start)
				s_next.ctrl.abort = 1'b1;
			s_next.ctrl.start = 1'b0;
			s_next.ctrl.permit = 1'b0;
			s_next.state = DEEPC_IDLE;
			s_next.window = 1'b0;
			s_next.key_first = 1'b0;
			mem_we = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_reg <= '0;
			s_reg.state <= DEEPC_IDLE;
			s_reg.ctrl <= deepc_ctrl_t'(11'h000);
		end
		else
			s_reg <= s_next;
	end

	// Array storage, no reset: contents are nonvolatile
	always_ff @(posedge core_clk)
	begin
		if (mem_we)
			array_reg[s_reg.index] <= mem_wdata;
	end
endmodule
`default_nettype wire

// ==== verif/deepc_asserts.sv ====
// Port checker for the EEPROM controller
`timescale 1ns/1ns
`default_nettype none
module deepc_asserts
	import deepc_pkg::*;
#(
	parameter int CELL_CYC = CELL_CYCLES
)
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        external_reset_pin,
	input wire logic        watchdog_reset,
	input wire logic        completion_interrupt_flag,
	input wire logic        busy
);
	// ====
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer timing");
	a_ctl_unimpl: assert property (avs_read && !avs_waitrequest
		&& avs_address == ADDR_CONTROL |-> avs_readdata[11:7] == 5'h00)
		else $error("unimplemented bits set");
	a_irq_pulse: assert property (completion_interrupt_flag |=> !completion_interrupt_flag)
		else $error("flag not a pulse");
	a_busy_irq: assert property ($fell(busy) && !$past(external_reset_pin)
		&& !$past(watchdog_reset) |-> completion_interrupt_flag)
		else $error("no flag at completion");
	a_irq_cause: assert property (completion_interrupt_flag |-> !busy && $past(busy))
		else $error("flag without cycle end");
	a_start_unlock: assert property ($rose(busy) |-> $past(avs_write)
		&& $past(avs_address) == ADDR_CONTROL && $past(avs_writedata[15:14]) == 2'b11
		&& $past(avs_write, 2) && $past(avs_address, 2) == ADDR_KEY
		&& $past(avs_writedata[7:0], 2) == KEY_SECOND)
		else $error("start without unlock");
	a_abort_stop: assert property ((external_reset_pin || watchdog_reset) && busy |=> !busy)
		else $error("cycle not aborted");
	c_start: cover property ($rose(busy));
	c_done: cover property ($fell(busy) && completion_interrupt_flag);
	c_abort: cover property (watchdog_reset && busy);
endmodule
bind deepc_top deepc_asserts #(.CELL_CYC(CELL_CYC)) u_deepc_asserts (
	.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.external_reset_pin(external_reset_pin), .watchdog_reset(watchdog_reset),
	.completion_interrupt_flag(completion_interrupt_flag), .busy(busy));
`default_nettype wire

// ==== verif/deepc_tb_top.sv ====
// Self-checking bench for the EEPROM controller
`timescale 1ns/1ns
`default_nettype none
module deepc_tb_top
	import deepc_pkg::*;
;
	// ====
	// Signals and model
	logic core_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, busy, tblwt_valid = 0;
	logic external_reset_pin = 0, watchdog_reset = 0, completion_interrupt_flag, avs_waitrequest;
	logic [3:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata;
	logic [23:0] tblwt_addr = 0, tblrd_addr = 0;
	logic [15:0] tblwt_data = 0, tblrd_data, rv, d;
	logic [15:0] mem [256];
	logic [5:0] ops [3] = '{OP_ERASE1, OP_ERASE4, OP_ERASE8};
	int fails = 0, cmp_count = 0, j, k, n;
	// Short cell time keeps bulk erase quick
	deepc_top #(.CELL_CYC(4)) u_deepc_top (.core_clk(core_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tblwt_valid(tblwt_valid), .tblwt_addr(tblwt_addr),
		.tblwt_data(tblwt_data), .tblrd_addr(tblrd_addr), .tblrd_data(tblrd_data),
		.external_reset_pin(external_reset_pin), .watchdog_reset(watchdog_reset),
		.completion_interrupt_flag(completion_interrupt_flag), .busy(busy));
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	function automatic logic [23:0] ea(input int i);
		return ARRAY_BASE + 24'(2 * i);
	endfunction
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Request held until waitrequest seen low before an edge
	task automatic xfer(input logic r, input logic [3:0] a, input logic [15:0] v);
		logic w;
		avs_read <= r;
		avs_write <= !r;
		avs_address <= a;
		avs_writedata <= {16'h0000, v};
		w = 1;
		while (w)
		begin
			@(negedge core_clk);
			w = (avs_waitrequest !== 1'b0);
			rv = avs_readdata[15:0];
			@(posedge core_clk);
		end
	endtask
	task automatic idle();
		avs_read <= 0;
		avs_write <= 0;
		@(posedge core_clk);
	endtask
	task automatic tw(input logic [23:0] a, input logic [15:0] v);
		tblwt_valid <= 1;
		tblwt_addr <= a;
		tblwt_data <= v;
		@(posedge core_clk);
		tblwt_valid <= 0;
		@(posedge core_clk);
	endtask
	task automatic tr(input logic [23:0] a, input logic [15:0] e);
		tblrd_addr <= a;
		@(posedge core_clk);
		@(negedge core_clk);
		chk(e, tblrd_data);
		@(posedge core_clk);
	endtask
	task automatic start(input logic [15:0] c);
		xfer(0, ADDR_CONTROL, c & 16'h7fff);
		xfer(0, ADDR_KEY, {8'h00, KEY_FIRST});
		xfer(0, ADDR_KEY, {8'h00, KEY_SECOND});
		xfer(0, ADDR_CONTROL, c);
		idle();
	endtask
	task automatic fin();
		int t;
		t = 0;
		do
		begin
			@(negedge core_clk);
			t++;
		end
		while (busy !== 1'b0 && t < 3000);
		chk(16'h0001, {15'h0000, completion_interrupt_flag});
		@(posedge core_clk);
		xfer(1, ADDR_CONTROL, 16'h0000);
		idle();
		chk(16'h0000, rv & 16'he000);
	endtask
	task automatic prog(input int i, input logic [15:0] c);
		d = 16'($urandom);
		tw(ea(i) | 24'($urandom % 2), d);
		xfer(1, ADDR_ARRAY_DATA, 16'h0000);
		chk(d, rv);
		start(c);
		// Early state tells an erase-first write from a skip-erase one
		xfer(1, ADDR_STATUS, 16'h0000);
		idle();
		chk({12'h000, (c[BIT_SKIP] ? DEEPC_WRITE : DEEPC_ERASE)}, rv);
		fin();
		mem[i] = d;
	endtask
	// Start attempt that must be ignored
	task automatic refuse(input logic [15:0] p, input logic [7:0] k1, input bit gap);
		xfer(0, ADDR_CONTROL, p);
		xfer(0, ADDR_KEY, {8'h00, KEY_FIRST});
		xfer(0, ADDR_KEY, {8'h00, k1});
		xfer(0, ADDR_KEY, {8'h00, KEY_SECOND});
		if (gap)
			idle();
		xfer(0, ADDR_CONTROL, p | 16'h8000);
		xfer(1, ADDR_CONTROL, 16'h0000);
		idle();
		chk(16'h0000, rv & 16'h8000);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#800000;
		fails++;
		print_verdict();
	end
	// ====
	// Tests
	initial
	begin
		d = 16'($urandom(32'h55b190b1));
		repeat (2) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		xfer(1, ADDR_CONTROL, 0);
		chk(CONTROL_RESET, rv);
		xfer(1, ADDR_KEY, 0);
		chk(16'h0000, rv);
		xfer(0, ADDR_CONTROL, 16'h4f80);
		xfer(1, ADDR_CONTROL, 0);
		chk(16'h4000, rv);
		idle();
		$display("test 1 done");
		for (j = 0; j < 4; j++)
		begin
			k = int'($urandom % 256);
			prog(k, 16'hc004);
			tr(ea(k), mem[k]);
		end
		$display("test 2 done");
		for (j = 0; j < 3; j++)
		begin
			k = 16 * j + 32;
			n = (j == 0) ? 1 : 4 * j;
			prog(k + n - 1, 16'hc004);
			prog(k + n, 16'hc004);
			tw(ea(k), 16'h0000);
			start({10'h301, ops[j]});
			fin();
			tr(ea(k + n - 1), 16'hffff);
			tr(ea(k + n), mem[k + n]);
		end
		prog(71, 16'hd004);
		tr(ea(71), mem[71]);
		start(16'hc07f);
		fin();
		tr(ea(72), mem[72]);
		$display("test 3 done");
		refuse(16'h4004, 8'h11, 0);
		refuse(16'h4004, KEY_FIRST, 1);
		refuse(16'h0004, KEY_FIRST, 0);
		$display("test 4 done");
		for (j = 0; j < 2; j++)
		begin
			start(16'hc05a);
			@(posedge core_clk);
			external_reset_pin <= (j == 0);
			watchdog_reset <= (j == 1);
			@(posedge core_clk);
			external_reset_pin <= 0;
			watchdog_reset <= 0;
			@(posedge core_clk);
			xfer(1, ADDR_CONTROL, 0);
			idle();
			chk(16'h2000, rv & 16'ha000);
		end
		// Abort bit written high on purpose: launch must clear it
		start(16'he050);
		xfer(0, ADDR_CONTROL, 16'h0000);
		xfer(1, ADDR_CONTROL, 16'h0000);
		idle();
		chk(16'hc050, rv);
		fin();
		tr(ea(72), 16'hffff);
		tr(ea(k), 16'hffff);
		$display("test 5 done");
		print_verdict();
	end
endmodule
`default_nettype wire
